// ---- gpir_regs.sv ----
// Overview of operation
// - Writing one to a clear register bit clears that pin's pending bit.
// - Writing one to a force register bit sets pending at once, for testing.
// - Upper-bank pins drive the interrupt only when their mask bit is set.
// - Reading the upper pending register returns pending bits of pins 49 to 32.
// - Lower-bank bit n maps to pin n; all bits reset to zero.
// - Upper-bank bit n maps to pin n plus 32; bits 31-18 read zero.
// - A lower-bank mask register lets set bits drive the interrupt.
// - Reading the lower pending register returns pending bits of pins 31 to 0.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`include "gpir_consts.svh"
module gpir_regs #(
    parameter int LOW_W = `GPIR_LOW_W,
    parameter int HIGH_W = `GPIR_HIGH_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`GPIR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`GPIR_DAT_W-1:0] wb_dat_i,
    output logic [`GPIR_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [LOW_W-1:0] pin_event_low,
    input wire logic [HIGH_W-1:0] pin_event_high,
    output logic irq
);
    gpir_pkg::gpir_wb_req_t req;
    logic take;
    logic wr;
    logic [`GPIR_DAT_W-1:0] wmask;
    logic [`GPIR_DAT_W-1:0] next_rdata;
    logic hit_mask_low;
    logic hit_pend_low;
    logic hit_clr_low;
    logic hit_force_low;
    logic hit_mask_high;
    logic hit_pend_high;
    logic hit_clr_high;
    logic hit_force_high;
    logic [LOW_W-1:0] pending_low;
    logic [LOW_W-1:0] enable_low;
    logic [HIGH_W-1:0] pending_high;
    logic [HIGH_W-1:0] enable_high;
    logic irq_low;
    logic irq_high;

    assign req = '{we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

    gpir_wb_port u_port (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o),
        .take(take)
    );

    // Byte lanes gate every write, including the write-one registers.
    assign wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
    assign wr = take && req.we;

    assign hit_mask_low = (req.adr == `GPIR_OFF_MASK_LOW);
    assign hit_pend_low = (req.adr == `GPIR_OFF_PEND_LOW);
    assign hit_clr_low = (req.adr == `GPIR_OFF_CLR_LOW);
    assign hit_force_low = (req.adr == `GPIR_OFF_FORCE_LOW);
    assign hit_mask_high = (req.adr == `GPIR_OFF_MASK_HIGH);
    assign hit_pend_high = (req.adr == `GPIR_OFF_PEND_HIGH);
    assign hit_clr_high = (req.adr == `GPIR_OFF_CLR_HIGH);
    assign hit_force_high = (req.adr == `GPIR_OFF_FORCE_HIGH);

    // Lower bank: bit n is pin n.
    gpir_bank #(
        .W(LOW_W)
    ) u_low (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .evt(pin_event_low),
        .wdata(req.dat[LOW_W-1:0]),
        .wmask(wmask[LOW_W-1:0]),
        .wr_clr(wr && hit_clr_low),
        .wr_set(wr && hit_force_low),
        .wr_mask(wr && hit_mask_low),
        .pending(pending_low),
        .enable(enable_low),
        .irq_any(irq_low)
    );

    // Upper bank: bit n is pin n plus 32; bits above are not stored.
    gpir_bank #(
        .W(HIGH_W)
    ) u_high (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .evt(pin_event_high),
        .wdata(req.dat[HIGH_W-1:0]),
        .wmask(wmask[HIGH_W-1:0]),
        .wr_clr(wr && hit_clr_high),
        .wr_set(wr && hit_force_high),
        .wr_mask(wr && hit_mask_high),
        .pending(pending_high),
        .enable(enable_high),
        .irq_any(irq_high)
    );

    // Write-one registers and unmapped addresses read as zero.
    always_comb begin
        next_rdata = `GPIR_RDATA_RST;
        case (1'b1)
            hit_mask_low: begin
                next_rdata[LOW_W-1:0] = enable_low;
            end
            hit_pend_low: begin
                next_rdata[LOW_W-1:0] = pending_low;
            end
            hit_mask_high: begin
                next_rdata[HIGH_W-1:0] = enable_high;
            end
            hit_pend_high: begin
                next_rdata[HIGH_W-1:0] = pending_high;
            end
            default: begin
                next_rdata = `GPIR_RDATA_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= `GPIR_RDATA_RST;
        end else if (take && !req.we) begin
            wb_dat_o <= next_rdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_low || irq_high;
        end
    end

    // Helper terms read only by the checks below.
    logic [LOW_W-1:0] chk_clr_low;
    logic [HIGH_W-1:0] chk_clr_high;
    logic [LOW_W-1:0] chk_set_low;
    logic [HIGH_W-1:0] chk_set_high;
    logic [LOW_W-1:0] chk_ev_hit_low;
    logic chk_any_on;
    logic chk_rd_pend_low;
    logic chk_rd_pend_high;
    logic chk_rd_mask_high;
    logic chk_wr_mask_low;

    assign chk_clr_low = (wr && hit_clr_low)
        ? (req.dat[LOW_W-1:0] & wmask[LOW_W-1:0] & ~pin_event_low) : '0;
    assign chk_clr_high = (wr && hit_clr_high)
        ? (req.dat[HIGH_W-1:0] & wmask[HIGH_W-1:0] & ~pin_event_high) : '0;
    assign chk_set_low = (wr && hit_force_low)
        ? (req.dat[LOW_W-1:0] & wmask[LOW_W-1:0]) : '0;
    assign chk_set_high = (wr && hit_force_high)
        ? (req.dat[HIGH_W-1:0] & wmask[HIGH_W-1:0]) : '0;
    assign chk_ev_hit_low = (wr && hit_clr_low) ? pin_event_low : '0;
    assign chk_any_on = |(pending_low & enable_low) || |(pending_high & enable_high);
    assign chk_rd_pend_low = take && !req.we && hit_pend_low;
    assign chk_rd_pend_high = take && !req.we && hit_pend_high;
    assign chk_rd_mask_high = take && !req.we && hit_mask_high;
    assign chk_wr_mask_low = wr && hit_mask_low && (req.sel == 4'hF);

    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_irq_follows;
        ##2 irq;
    endsequence

    chk_clear_low: assert property (
        (|chk_clr_low) |=> ((pending_low & $past(chk_clr_low)) == '0)
    ) else $error("lower clear write left a pending bit set");

    chk_clear_high: assert property (
        (|chk_clr_high) |=> ((pending_high & $past(chk_clr_high)) == '0)
    ) else $error("upper clear write left a pending bit set");

    chk_clear_keep: assert property (
        (wr && hit_clr_low) |=> ((pending_low & $past(pending_low)) ==
            ($past(pending_low) & ~$past(req.dat[LOW_W-1:0] & wmask[LOW_W-1:0])))
            || (|$past(pin_event_low))
    ) else $error("bits written zero to a clear register changed");

    chk_force_low: assert property (
        (|chk_set_low) |=> ((pending_low & $past(chk_set_low)) == $past(chk_set_low))
    ) else $error("lower force write did not set pending");

    chk_force_high: assert property (
        (|chk_set_high) |=> ((pending_high & $past(chk_set_high)) == $past(chk_set_high))
    ) else $error("upper force write did not set pending");

    chk_force_irq: assert property (
        (|(chk_set_high & enable_high)) |-> s_irq_follows
    ) else $error("forced enabled bit raised no interrupt");

    chk_mask_gate: assert property (
        irq |-> $past(chk_any_on)
    ) else $error("interrupt without an enabled pending bit");

    chk_irq_level: assert property (
        chk_any_on |=> irq
    ) else $error("enabled pending bit did not raise interrupt");

    chk_irq_drop: assert property (
        !chk_any_on |=> !irq
    ) else $error("interrupt stayed high with nothing enabled");

    chk_event_wins: assert property (
        (|chk_ev_hit_low) |=> ((pending_low & $past(chk_ev_hit_low)) == $past(chk_ev_hit_low))
    ) else $error("pin event lost to a simultaneous clear");

    chk_read_high: assert property (
        chk_rd_pend_high |=> wb_ack_o && (wb_dat_o[HIGH_W-1:0] == $past(pending_high))
    ) else $error("upper pending read returned wrong data");

    chk_read_low: assert property (
        chk_rd_pend_low |=> wb_ack_o && (wb_dat_o == $past(pending_low))
    ) else $error("lower pending read returned wrong data");

    chk_rsvd_zero: assert property (
        (chk_rd_pend_high || chk_rd_mask_high)
            |=> (wb_dat_o[`GPIR_DAT_W-1:HIGH_W] == `GPIR_RSVD_VAL)
    ) else $error("reserved upper bits read nonzero");

    chk_mask_high_rd: assert property (
        chk_rd_mask_high |=> (wb_dat_o[HIGH_W-1:0] == $past(enable_high))
    ) else $error("upper mask read returned wrong data");

    chk_mask_low_wr: assert property (
        chk_wr_mask_low |=> (enable_low == $past(req.dat))
    ) else $error("lower mask write not stored");

    chk_reset_zero: assert property (
        $past(sys_rst) |-> (pending_low == '0) && (pending_high == '0) && !irq
    ) else $error("pending bits not zero after reset");

    chk_bus_ack: assert property (
        take |=> s_ack_pulse
    ) else $error("bus acknowledge not a single cycle pulse");

    chk_no_ack_idle: assert property (
        (!wb_cyc_i || !wb_stb_i) && !wb_ack_o |=> !wb_ack_o
    ) else $error("acknowledge without a request");
endmodule

// ---- gpir_consts.svh ----
`ifndef GPIR_CONSTS_SVH
`define GPIR_CONSTS_SVH

// Bus and bank geometry.
`define GPIR_ADR_W 10
`define GPIR_DAT_W 32
`define GPIR_LOW_W 32
`define GPIR_HIGH_W 18
`define GPIR_RSVD_W 14

// Register byte offsets.
`define GPIR_OFF_MASK_LOW 10'h200
`define GPIR_OFF_PEND_LOW 10'h204
`define GPIR_OFF_CLR_LOW 10'h208
`define GPIR_OFF_FORCE_LOW 10'h20C
`define GPIR_OFF_MASK_HIGH 10'h210
`define GPIR_OFF_PEND_HIGH 10'h214
`define GPIR_OFF_CLR_HIGH 10'h218
`define GPIR_OFF_FORCE_HIGH 10'h21C

// Reset values: pending and mask are one bit, replicated across a bank; read data is full-width zero, the reserved value 14 bits of zero.
`define GPIR_PEND_RST 1'b0
`define GPIR_MASK_RST 1'b0
`define GPIR_RDATA_RST 32'h0000_0000
`define GPIR_RSVD_VAL 14'h0000

`endif

// ---- gpir_pkg.sv ----
package gpir_pkg;

    typedef struct packed {
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } gpir_wb_req_t;

    typedef enum logic [1:0] {
        GPIR_BUS_IDLE = 2'b01,
        GPIR_BUS_ACK = 2'b10
    } gpir_bus_state_t;

endpackage

// ---- gpir_wb_port.sv ----
`timescale 1ns/1ns
module gpir_wb_port (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic take
);
    gpir_pkg::gpir_bus_state_t state;
    gpir_pkg::gpir_bus_state_t next_state;

    always_comb begin
        case (state)
            gpir_pkg::GPIR_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    next_state = gpir_pkg::GPIR_BUS_ACK;
                end else begin
                    next_state = gpir_pkg::GPIR_BUS_IDLE;
                end
            end
            gpir_pkg::GPIR_BUS_ACK: begin
                next_state = gpir_pkg::GPIR_BUS_IDLE;
            end
            default: begin
                next_state = gpir_pkg::GPIR_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= gpir_pkg::GPIR_BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Acknowledge comes straight from the state flip-flop.
    assign wb_ack_o = state[1];
    assign take = state[0] && wb_cyc_i && wb_stb_i;
endmodule

// ---- gpir_bank.sv ----
`timescale 1ns/1ns
`include "gpir_consts.svh"
module gpir_bank #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] evt,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] wmask,
    input wire logic wr_clr,
    input wire logic wr_set,
    input wire logic wr_mask,
    output logic [W-1:0] pending,
    output logic [W-1:0] enable,
    output logic irq_any
);
    logic [W-1:0] clr_vec;
    logic [W-1:0] set_vec;
    logic [W-1:0] next_pending;

    assign clr_vec = wr_clr ? (wdata & wmask) : {W{1'b0}};
    assign set_vec = wr_set ? (wdata & wmask) : {W{1'b0}};
    // A pin event or a forced bit beats a clear in the same cycle.
    assign next_pending = (pending & ~clr_vec) | set_vec | evt;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= {W{`GPIR_PEND_RST}};
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable <= {W{`GPIR_MASK_RST}};
        end else if (wr_mask) begin
            enable <= (enable & ~wmask) | (wdata & wmask);
        end
    end

    assign irq_any = |(pending & enable);
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "gpir_consts.svh"
module testbench;
    logic core_clk;
    logic sys_rst;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [31:0] pin_event_low;
    logic [17:0] pin_event_high;
    logic irq;
    int num_errors;
    int checked;

    gpir_regs uut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .pin_event_low(pin_event_low),
        .pin_event_high(pin_event_high),
        .irq(irq)
    );

    always #50 core_clk = ~core_clk;

    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t value got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input logic exp);
        checked++;
        if (irq !== exp) begin
            num_errors++;
            $display("[ERR] %0t irq got %b expected %b", $time, irq, exp);
        end
    endtask

    // One classic cycle: request held until ack is sampled, then released.
    task automatic xfer(input logic we, input logic [9:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) @(posedge core_clk);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] q;
        xfer(1'b1, a, d, s, q);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
        chk_val(q, exp);
    endtask

    // Pin events stand for one cycle; pending lands at the edge that ends them.
    task automatic pulse(input logic [31:0] lo, input logic [17:0] hi);
        @(posedge core_clk);
        pin_event_low <= lo;
        pin_event_high <= hi;
        @(posedge core_clk);
        pin_event_low <= 32'h0000_0000;
        pin_event_high <= 18'h0_0000;
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        pin_event_low = 32'h0000_0000;
        pin_event_high = 18'h0_0000;
        num_errors = 0;
        checked = 0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(10'h200 + 10'(4 * i), 32'h0000_0000);
        end
        chk_irq(1'b0);
        wr(`GPIR_OFF_MASK_LOW, 32'hFFFF_FFFF);
        rd_chk(`GPIR_OFF_MASK_LOW, 32'hFFFF_FFFF);
        wr(`GPIR_OFF_MASK_LOW, 32'hAAAA_5555, 4'h5);
        rd_chk(`GPIR_OFF_MASK_LOW, 32'hFFAA_FF55);
        wr(`GPIR_OFF_MASK_HIGH, 32'hFFFF_FFFF);
        rd_chk(`GPIR_OFF_MASK_HIGH, 32'h0003_FFFF);
        wr(`GPIR_OFF_MASK_LOW, 32'h0000_0000);
        wr(`GPIR_OFF_MASK_HIGH, 32'h0000_0000);
        wr(`GPIR_OFF_FORCE_LOW, 32'h8000_0001);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h8000_0001);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h8000_0001);
        chk_irq(1'b0);
        wr(`GPIR_OFF_MASK_LOW, 32'h0000_0001);
        settle();
        chk_irq(1'b1);
        wr(`GPIR_OFF_CLR_LOW, 32'h0000_0001);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h8000_0000);
        chk_irq(1'b0);
        wr(`GPIR_OFF_CLR_LOW, 32'h8000_0000);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h0000_0000);
        wr(`GPIR_OFF_FORCE_HIGH, 32'hFFFF_FFFF);
        rd_chk(`GPIR_OFF_PEND_HIGH, 32'h0003_FFFF);
        chk_irq(1'b0);
        wr(`GPIR_OFF_MASK_HIGH, 32'h0002_0000);
        settle();
        chk_irq(1'b1);
        wr(`GPIR_OFF_CLR_HIGH, 32'h0002_0000);
        rd_chk(`GPIR_OFF_PEND_HIGH, 32'h0001_FFFF);
        settle();
        chk_irq(1'b0);
        wr(`GPIR_OFF_CLR_HIGH, 32'hFFFF_FFFF);
        rd_chk(`GPIR_OFF_PEND_HIGH, 32'h0000_0000);
        // A forced bit that is already enabled must raise the interrupt by itself.
        wr(`GPIR_OFF_FORCE_HIGH, 32'h0002_0000);
        settle();
        chk_irq(1'b1);
        wr(`GPIR_OFF_CLR_HIGH, 32'h0002_0000);
        settle();
        chk_irq(1'b0);
        wr(`GPIR_OFF_MASK_LOW, 32'h0000_0020);
        pulse(32'h0000_0020, 18'h0_0001);
        settle();
        chk_irq(1'b1);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h0000_0020);
        rd_chk(`GPIR_OFF_PEND_HIGH, 32'h0000_0001);
        // A clear taken in the same cycle as a new event must lose to it.
        fork
            wr(`GPIR_OFF_CLR_LOW, 32'h0000_0020);
            pulse(32'h0000_0020, 18'h0_0000);
        join
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h0000_0020);
        wr(`GPIR_OFF_PEND_LOW, 32'h0000_0000);
        wr(`GPIR_OFF_PEND_HIGH, 32'h0000_0000);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h0000_0020);
        rd_chk(`GPIR_OFF_PEND_HIGH, 32'h0000_0001);
        rd_chk(`GPIR_OFF_CLR_LOW, 32'h0000_0000);
        rd_chk(`GPIR_OFF_FORCE_HIGH, 32'h0000_0000);
        wr(10'h201, 32'hFFFF_FFFF);
        wr(10'h220, 32'hFFFF_FFFF);
        rd_chk(10'h220, 32'h0000_0000);
        rd_chk(`GPIR_OFF_MASK_LOW, 32'h0000_0020);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk_irq(1'b0);
        rd_chk(`GPIR_OFF_PEND_LOW, 32'h0000_0000);
        rd_chk(`GPIR_OFF_PEND_HIGH, 32'h0000_0000);
        rd_chk(`GPIR_OFF_MASK_LOW, 32'h0000_0000);
        wrap_up();
    end
endmodule
